// *** verilog/ptid_decoder.sv ***
// Purpose : PCI target address and command decoder with two target images
// Assumes : PCI pins are synchronous to clk_i; data phases handled elsewhere
// Notes   : PCI pins share clk_i, so no resync stage that would cost devsel timing
// Overview of operation
// R1 - Claim only enabled-image address and command hits
// R2 - Software keeps images apart from registers
// R3 - Two equal images steer local bus cycle
// R4 - Disabled image never matches; both off, none
// R5 - Space bit selects memory or I/O commands
// R6 - Four-bit size gives sixteen sizes, 2 GB max
// R7 - Software aligns base to size, upper bits
// R8 - Compare only size-implied upper address bits
// R9 - DEVSEL by second clock; medium timing reported
// R10 - Respond to I/O, memory, type 0 config
// R11 - Read multiple/line as read, invalidate as write
// R12 - Translation field replaces upper address bits
// R13 - Image transaction code drives local code lines
// R14 - Image port width sizes local cycles
// R15 - Posted write enable: posted else delayed
// R16 - Image prefetch enable for reads
// R17 - Image burst write enable
// R18 - Invert endian flips global byte order
// R19 - Global prefetch count; image 1 alternative
// R20 - Global burst of four versus two-three
// R21 - Option for single-beat prefetch in burst mode
// R22 - Option holds bus busy across cycles
// R23 - Ignore type 1 config; never forward config
// R24 - Size sets address split; largest swaps bit 31
// R25 - Size code 0 is 64 KB, doubling
// R26 - Port width 32, 16 or 8 bits

`timescale 1ns/100ps

module ptid_decoder (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // APB register bus
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // PCI address phase
  input  wire logic        frame_n_i,
  input  wire logic        irdy_n_i,
  input  wire logic        idsel_i,
  input  wire logic [31:0] ad_i,
  input  wire logic [3:0]  cbe_n_i,
  output logic             devsel_n_o,
  output logic             devsel_oe_n_o,
  // Configuration claim
  output logic             cfg_claim_o,
  output logic             cfg_write_o,
  output logic [7:0]       cfg_reg_o,
  // Local processor bus cycle request
  output logic             lb_valid_o,
  output logic             lb_image_o,
  output logic [31:0]      lb_addr_o,
  output logic             lb_write_o,
  output logic             lb_io_o,
  output logic [3:0]       lb_tc_o,
  output logic [1:0]       lb_port_width_o,
  output logic             lb_posted_o,
  output logic             lb_prefetch_o,
  output logic [5:0]       lb_prefetch_count_o,
  output logic             lb_burst_write_o,
  output logic             lb_byte_order_o,
  output logic             lb_burst4_o,
  output logic             lb_single_beat_prefetch_o,
  output logic             lb_hold_bus_busy_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ptid_pkg::ptid_state_e st;
    logic                  frame_prev;
    logic [1:0][15:0]      base, trans;
    logic [1:0]            en, io_space;
    logic [1:0][3:0]       size, tc;
    logic [1:0][1:0]       pw;
    logic [1:0]            posted, pref, bwr, inv;
    logic [5:0]            gpcnt;
    logic                  border;
    logic [5:0]            i1pcnt;
    logic                  perimg, burst4, single, holdbb;
    logic [31:0]           addr_q;
    logic [3:0]            cmd_q;
    logic                  idsel_q;
    logic [31:0]           prdata;
    logic                  devsel, drive, cfg_claim, cfg_write;
    logic [7:0]            cfg_reg;
    logic                  lb_valid, lb_image;
    logic [31:0]           lb_addr;
    logic                  lb_write, lb_io;
    logic [3:0]            lb_tc;
    logic [1:0]            lb_pw;
    logic                  lb_posted, lb_pref;
    logic [5:0]            lb_pcnt;
    logic                  lb_bwr, lb_order, lb_burst4, lb_single, lb_holdbb;
    logic [15:0]           claim_cnt;
    logic                  last_img, last_cfg;
  } ptid_state_s;

  ptid_state_s s_r;
  ptid_state_s s_nxt;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Upper address bits that take part in the compare for a size code
  function automatic logic [15:0] size_mask(input logic [3:0] code);
    size_mask = 16'hffff << code;  // [R6] [R25]
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    merge = r;
  endfunction

  function automatic ptid_pkg::ptid_kind_e cmd_kind(input logic [3:0] cmd);
    ptid_pkg::ptid_kind_e k;
    k = ptid_pkg::KIND_NONE;
    unique case (cmd)
      ptid_pkg::CMD_IO_RD, ptid_pkg::CMD_IO_WR: begin
        k = ptid_pkg::KIND_IO;  // [R10]
      end
      ptid_pkg::CMD_MEM_RD, ptid_pkg::CMD_MEM_WR,
      ptid_pkg::CMD_MEM_RDM, ptid_pkg::CMD_MEM_RDL, ptid_pkg::CMD_MEM_WRI: begin
        k = ptid_pkg::KIND_MEM;  // [R10] [R11]
      end
      ptid_pkg::CMD_CFG_RD, ptid_pkg::CMD_CFG_WR: begin
        k = ptid_pkg::KIND_CFG;  // [R10]
      end
      default: begin
        k = ptid_pkg::KIND_NONE;
      end
    endcase
    cmd_kind = k;
  endfunction

  // ----------------------------------------------------------------
  // Register read views
  // ----------------------------------------------------------------
  logic [1:0][31:0] adr_rd, ctl_rd;
  logic [31:0]      misc_rd, misb_rd, stat_rd;

  for (genvar g = 0; g < ptid_pkg::NUM_IMAGES; g++) begin : g_view
    always_comb begin
      adr_rd[g] = '0;
      adr_rd[g][ptid_pkg::ADR_BASE_LSB +: 16]  = s_r.base[g];
      adr_rd[g][ptid_pkg::ADR_TRANS_LSB +: 16] = s_r.trans[g];
      ctl_rd[g] = '0;
      ctl_rd[g][ptid_pkg::CTL_EN_BIT]        = s_r.en[g];
      ctl_rd[g][ptid_pkg::CTL_IO_BIT]        = s_r.io_space[g];
      ctl_rd[g][ptid_pkg::CTL_SIZE_LSB +: 4] = s_r.size[g];
      ctl_rd[g][ptid_pkg::CTL_TC_LSB +: 4]   = s_r.tc[g];
      ctl_rd[g][ptid_pkg::CTL_PW_LSB +: 2]   = s_r.pw[g];
      ctl_rd[g][ptid_pkg::CTL_POST_BIT]      = s_r.posted[g];
      ctl_rd[g][ptid_pkg::CTL_PREF_BIT]      = s_r.pref[g];
      ctl_rd[g][ptid_pkg::CTL_BWR_BIT]       = s_r.bwr[g];
      ctl_rd[g][ptid_pkg::CTL_INV_BIT]       = s_r.inv[g];
    end
  end

  always_comb begin
    misc_rd = '0;
    misc_rd[ptid_pkg::MISC_PCNT_LSB +: 6] = s_r.gpcnt;
    misc_rd[ptid_pkg::MISC_ORDER_BIT]     = s_r.border;
    misb_rd = '0;
    misb_rd[ptid_pkg::MISB_PCNT_LSB +: 6] = s_r.i1pcnt;
    misb_rd[ptid_pkg::MISB_PERIMG_BIT]    = s_r.perimg;
    misb_rd[ptid_pkg::MISB_BURST4_BIT]    = s_r.burst4;
    misb_rd[ptid_pkg::MISB_SINGLE_BIT]    = s_r.single;
    misb_rd[ptid_pkg::MISB_HOLDBB_BIT]    = s_r.holdbb;
    stat_rd = '0;
    stat_rd[ptid_pkg::STAT_DEVSEL_LSB +: 2] = ptid_pkg::DEVSEL_MEDIUM;  // [R9]
    stat_rd[ptid_pkg::STAT_IMG_BIT]         = s_r.last_img;
    stat_rd[ptid_pkg::STAT_CFG_BIT]         = s_r.last_cfg;
    stat_rd[ptid_pkg::STAT_BUSY_BIT]        = (s_r.st != ptid_pkg::ST_IDLE);
    stat_rd[ptid_pkg::STAT_CNT_LSB +: 16]   = s_r.claim_cnt;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic                 apb_wr, apb_setup, mapped, space_ok, cfg_hit, sel;
  logic [31:0]          rd_word, wr_word;
  logic [1:0]           hit;
  logic [15:0]          mask;
  ptid_pkg::ptid_kind_e kind;

  always_comb begin
    s_nxt     = s_r;
    apb_wr    = psel_i && penable_i && pwrite_i;
    apb_setup = psel_i && !penable_i;
    mapped    = 1'b0;
    rd_word   = '0;
    wr_word   = '0;
    hit       = '0;
    space_ok  = 1'b0;
    cfg_hit   = 1'b0;
    sel       = 1'b0;
    mask      = '0;
    kind      = cmd_kind(s_r.cmd_q);

    s_nxt.lb_valid   = 1'b0;
    s_nxt.cfg_claim  = 1'b0;
    s_nxt.frame_prev = frame_n_i;

    // Register decode
    for (int i = 0; i < ptid_pkg::NUM_IMAGES; i++) begin
      if (paddr_i == 8'(ptid_pkg::IMG0_ADDR_OFF + i * ptid_pkg::IMG_STRIDE)) begin
        mapped  = 1'b1;
        rd_word = adr_rd[i];
        if (apb_wr) begin
          wr_word        = merge(adr_rd[i], pwdata_i, pstrb_i);
          s_nxt.base[i]  = wr_word[ptid_pkg::ADR_BASE_LSB +: 16];
          s_nxt.trans[i] = wr_word[ptid_pkg::ADR_TRANS_LSB +: 16];
        end
      end
      if (paddr_i == 8'(ptid_pkg::IMG0_CTL_OFF + i * ptid_pkg::IMG_STRIDE)) begin
        mapped  = 1'b1;
        rd_word = ctl_rd[i];
        if (apb_wr) begin
          wr_word           = merge(ctl_rd[i], pwdata_i, pstrb_i);
          s_nxt.en[i]       = wr_word[ptid_pkg::CTL_EN_BIT];
          s_nxt.io_space[i] = wr_word[ptid_pkg::CTL_IO_BIT];
          s_nxt.size[i]     = wr_word[ptid_pkg::CTL_SIZE_LSB +: 4];
          s_nxt.tc[i]       = wr_word[ptid_pkg::CTL_TC_LSB +: 4];
          s_nxt.pw[i]       = wr_word[ptid_pkg::CTL_PW_LSB +: 2];
          s_nxt.posted[i]   = wr_word[ptid_pkg::CTL_POST_BIT];
          s_nxt.pref[i]     = wr_word[ptid_pkg::CTL_PREF_BIT];
          s_nxt.bwr[i]      = wr_word[ptid_pkg::CTL_BWR_BIT];
          s_nxt.inv[i]      = wr_word[ptid_pkg::CTL_INV_BIT];
        end
      end
    end
    if (paddr_i == ptid_pkg::MISC_OFF) begin
      mapped  = 1'b1;
      rd_word = misc_rd;
      if (apb_wr) begin
        wr_word      = merge(misc_rd, pwdata_i, pstrb_i);
        s_nxt.gpcnt  = wr_word[ptid_pkg::MISC_PCNT_LSB +: 6];
        s_nxt.border = wr_word[ptid_pkg::MISC_ORDER_BIT];
      end
    end
    if (paddr_i == ptid_pkg::MISC_B_OFF) begin
      mapped  = 1'b1;
      rd_word = misb_rd;
      if (apb_wr) begin
        wr_word      = merge(misb_rd, pwdata_i, pstrb_i);
        s_nxt.i1pcnt = wr_word[ptid_pkg::MISB_PCNT_LSB +: 6];
        s_nxt.perimg = wr_word[ptid_pkg::MISB_PERIMG_BIT];
        s_nxt.burst4 = wr_word[ptid_pkg::MISB_BURST4_BIT];
        s_nxt.single = wr_word[ptid_pkg::MISB_SINGLE_BIT];
        s_nxt.holdbb = wr_word[ptid_pkg::MISB_HOLDBB_BIT];
      end
    end
    if (paddr_i == ptid_pkg::STATUS_OFF) begin
      mapped  = 1'b1;
      rd_word = stat_rd;
    end
    if (apb_setup) begin
      s_nxt.prdata = mapped ? rd_word : '0;
    end

    // Image hit decision on the captured address phase
    for (int i = 0; i < ptid_pkg::NUM_IMAGES; i++) begin
      mask     = size_mask(s_r.size[i]);
      space_ok = s_r.io_space[i] ? (kind == ptid_pkg::KIND_IO) : (kind == ptid_pkg::KIND_MEM);  // [R5]
      hit[i]   = s_r.en[i] && space_ok &&
                 (((s_r.addr_q[31:16] ^ s_r.base[i]) & mask) == 16'h0000);  // [R1] [R4] [R8]
    end
    // Only type 0 with IDSEL is claimed; type 1 falls through
    cfg_hit = (kind == ptid_pkg::KIND_CFG) && s_r.idsel_q &&
              (s_r.addr_q[1:0] == ptid_pkg::CFG_TYPE0);  // [R23]
    // Images never overlap when programmed legally; image 0 wins otherwise
    sel  = !hit[0];  // [R2]
    mask = size_mask(s_r.size[sel]);

    // Address phase tracking
    unique case (s_r.st)
      ptid_pkg::ST_IDLE: begin
        if (!frame_n_i && s_r.frame_prev) begin
          s_nxt.addr_q  = ad_i;
          s_nxt.cmd_q   = cbe_n_i;
          s_nxt.idsel_q = idsel_i;
          s_nxt.st      = ptid_pkg::ST_DECODE;
        end
      end
      ptid_pkg::ST_DECODE: begin
        if (hit != 2'b00) begin
          s_nxt.devsel    = 1'b1;  // [R9]
          s_nxt.drive     = 1'b1;
          s_nxt.st        = ptid_pkg::ST_CLAIMED;
          s_nxt.lb_valid  = 1'b1;  // [R3]
          s_nxt.lb_image  = sel;
          s_nxt.lb_addr   = {(s_r.trans[sel] & mask) | (s_r.addr_q[31:16] & ~mask),
                             s_r.addr_q[15:0]};  // [R12] [R24]
          s_nxt.lb_write  = s_r.cmd_q[0];  // [R11]
          s_nxt.lb_io     = (kind == ptid_pkg::KIND_IO);
          s_nxt.lb_tc     = s_r.tc[sel];  // [R13]
          s_nxt.lb_pw     = (s_r.pw[sel] == ptid_pkg::PW_16) ? ptid_pkg::PW_16 :
                            (s_r.pw[sel] == ptid_pkg::PW_8)  ? ptid_pkg::PW_8 : ptid_pkg::PW_32;  // [R14] [R26]
          s_nxt.lb_posted = s_r.cmd_q[0] && s_r.posted[sel];  // [R15]
          s_nxt.lb_pref   = !s_r.cmd_q[0] && s_r.pref[sel];  // [R16]
          s_nxt.lb_pcnt   = (sel && s_r.perimg) ? s_r.i1pcnt : s_r.gpcnt;  // [R19]
          s_nxt.lb_bwr    = s_r.cmd_q[0] && s_r.bwr[sel];  // [R17]
          s_nxt.lb_order  = s_r.border ^ s_r.inv[sel];  // [R18]
          s_nxt.lb_burst4 = s_r.burst4;  // [R20]
          s_nxt.lb_single = s_r.single;  // [R21]
          s_nxt.lb_holdbb = s_r.holdbb;  // [R22]
          s_nxt.claim_cnt = s_r.claim_cnt + 16'h0001;
          s_nxt.last_img  = sel;
          s_nxt.last_cfg  = 1'b0;
        end else if (cfg_hit) begin
          // Claimed locally, never passed to the processor bus
          s_nxt.devsel    = 1'b1;  // [R9] [R23]
          s_nxt.drive     = 1'b1;
          s_nxt.st        = ptid_pkg::ST_CLAIMED;
          s_nxt.cfg_claim = 1'b1;
          s_nxt.cfg_write = s_r.cmd_q[0];
          s_nxt.cfg_reg   = s_r.addr_q[7:0];
          s_nxt.claim_cnt = s_r.claim_cnt + 16'h0001;
          s_nxt.last_cfg  = 1'b1;
        end else begin
          s_nxt.st = ptid_pkg::ST_IGNORE;
        end
      end
      ptid_pkg::ST_CLAIMED: begin
        if (frame_n_i && irdy_n_i) begin
          s_nxt.devsel = 1'b0;
          s_nxt.st     = ptid_pkg::ST_TURN;
        end
      end
      ptid_pkg::ST_TURN: begin
        // Drive DEVSEL# high for one cycle before release
        s_nxt.drive = 1'b0;
        s_nxt.st    = ptid_pkg::ST_IDLE;
      end
      ptid_pkg::ST_IGNORE: begin
        if (frame_n_i && irdy_n_i) begin
          s_nxt.st = ptid_pkg::ST_IDLE;
        end
      end
      default: begin
        s_nxt.st = ptid_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_r            <= '0;
      s_r.st         <= ptid_pkg::ST_IDLE;
      s_r.frame_prev <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata_o                  = s_r.prdata;
  assign pready_o                  = 1'b1;
  assign pslverr_o                 = psel_i && penable_i && !mapped;
  assign {devsel_n_o, devsel_oe_n_o}           = {!s_r.devsel, !s_r.drive};
  assign {cfg_claim_o, cfg_write_o, cfg_reg_o} = {s_r.cfg_claim, s_r.cfg_write, s_r.cfg_reg};
  assign {lb_valid_o, lb_image_o, lb_addr_o, lb_write_o, lb_io_o, lb_tc_o} =
         {s_r.lb_valid, s_r.lb_image, s_r.lb_addr, s_r.lb_write, s_r.lb_io, s_r.lb_tc};
  assign {lb_port_width_o, lb_posted_o, lb_prefetch_o, lb_prefetch_count_o, lb_burst_write_o} =
         {s_r.lb_pw, s_r.lb_posted, s_r.lb_pref, s_r.lb_pcnt, s_r.lb_bwr};
  assign {lb_byte_order_o, lb_burst4_o, lb_single_beat_prefetch_o, lb_hold_bus_busy_o} =
         {s_r.lb_order, s_r.lb_burst4, s_r.lb_single, s_r.lb_holdbb};

endmodule

// *** verilog/ptid_pkg.sv ***
// Purpose : Constants and types of the PCI target image decoder
// Assumes : APB register bus with 32-bit data and 8-bit byte addresses
// Notes   : All writable register reset values are zero, so both images start disabled

package ptid_pkg;

  // ----------------------------------------------------------------
  // Bus and image geometry
  // ----------------------------------------------------------------
  localparam int unsigned PADDR_W    = 8;
  localparam int unsigned NUM_IMAGES = 2;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] IMG0_ADDR_OFF = 8'h00;
  localparam logic [7:0] IMG0_CTL_OFF  = 8'h04;
  localparam logic [7:0] IMG_STRIDE    = 8'h08;
  localparam logic [7:0] MISC_OFF      = 8'h10;
  localparam logic [7:0] MISC_B_OFF    = 8'h14;
  localparam logic [7:0] STATUS_OFF    = 8'h18;

  // ----------------------------------------------------------------
  // Image address register fields
  // ----------------------------------------------------------------
  localparam int unsigned ADR_BASE_LSB  = 16;
  localparam int unsigned ADR_TRANS_LSB = 0;

  // ----------------------------------------------------------------
  // Image control register fields
  // ----------------------------------------------------------------
  localparam int unsigned CTL_EN_BIT    = 31;
  localparam int unsigned CTL_IO_BIT    = 30;
  localparam int unsigned CTL_SIZE_LSB  = 24;
  localparam int unsigned CTL_TC_LSB    = 20;
  localparam int unsigned CTL_PW_LSB    = 16;
  localparam int unsigned CTL_POST_BIT  = 3;
  localparam int unsigned CTL_PREF_BIT  = 2;
  localparam int unsigned CTL_BWR_BIT   = 1;
  localparam int unsigned CTL_INV_BIT   = 0;

  // ----------------------------------------------------------------
  // Miscellaneous register fields
  // ----------------------------------------------------------------
  localparam int unsigned MISC_PCNT_LSB  = 0;
  localparam int unsigned MISC_ORDER_BIT = 8;
  localparam int unsigned MISB_PCNT_LSB  = 0;
  localparam int unsigned MISB_PERIMG_BIT = 8;
  localparam int unsigned MISB_BURST4_BIT = 9;
  localparam int unsigned MISB_SINGLE_BIT = 10;
  localparam int unsigned MISB_HOLDBB_BIT = 11;

  // ----------------------------------------------------------------
  // Status register fields and values
  // ----------------------------------------------------------------
  localparam int unsigned STAT_DEVSEL_LSB = 0;
  localparam int unsigned STAT_IMG_BIT    = 4;
  localparam int unsigned STAT_CFG_BIT    = 5;
  localparam int unsigned STAT_BUSY_BIT   = 6;
  localparam int unsigned STAT_CNT_LSB    = 16;
  localparam logic [1:0]  DEVSEL_MEDIUM   = 2'h1;

  // ----------------------------------------------------------------
  // Port width codes
  // ----------------------------------------------------------------
  localparam logic [1:0] PW_32 = 2'h0;
  localparam logic [1:0] PW_16 = 2'h1;
  localparam logic [1:0] PW_8  = 2'h2;

  // ----------------------------------------------------------------
  // PCI commands (C/BE lines during the address phase)
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_IO_RD   = 4'h2;
  localparam logic [3:0] CMD_IO_WR   = 4'h3;
  localparam logic [3:0] CMD_MEM_RD  = 4'h6;
  localparam logic [3:0] CMD_MEM_WR  = 4'h7;
  localparam logic [3:0] CMD_CFG_RD  = 4'ha;
  localparam logic [3:0] CMD_CFG_WR  = 4'hb;
  localparam logic [3:0] CMD_MEM_RDM = 4'hc;
  localparam logic [3:0] CMD_MEM_RDL = 4'he;
  localparam logic [3:0] CMD_MEM_WRI = 4'hf;
  localparam logic [1:0] CFG_TYPE0   = 2'h0;

  typedef enum logic [1:0] {
    KIND_NONE,
    KIND_MEM,
    KIND_IO,
    KIND_CFG
  } ptid_kind_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DECODE,
    ST_CLAIMED,
    ST_TURN,
    ST_IGNORE
  } ptid_state_e;

endpackage

// *** tb/ptid_checker.sv ***
// Purpose : Temporal checks on the decoder PCI ports
// Assumes : PCI pins share clk_i
// Notes   : Bound to every decoder instance
`timescale 1ns/100ps
module ptid_checker (
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic        frame_n_i,
  input wire logic        irdy_n_i,
  input wire logic        idsel_i,
  input wire logic [31:0] ad_i,
  input wire logic [3:0]  cbe_n_i,
  input wire logic        devsel_n_o,
  input wire logic        devsel_oe_n_o,
  input wire logic        cfg_claim_o,
  input wire logic        lb_valid_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence end_s;
    !devsel_n_o && frame_n_i && irdy_n_i;
  endsequence
  sequence rel_s;
    devsel_n_o && !devsel_oe_n_o ##1 devsel_oe_n_o;
  endsequence
  claim_time_a: assert property (lb_valid_o |-> $past(frame_n_i, 2) == 1'b0 && $past(frame_n_i, 3))
    else $error("claim not two clocks after address phase");
  claim_drive_a: assert property (lb_valid_o || cfg_claim_o |-> !devsel_n_o && !devsel_oe_n_o)
    else $error("claim without devsel");
  claim_excl_a: assert property (!(lb_valid_o && cfg_claim_o))
    else $error("config cycle forwarded");
  pulse_once_a: assert property (lb_valid_o |=> !lb_valid_o)
    else $error("claim pulse too long");
  cfg_qual_a: assert property (cfg_claim_o |-> $past(idsel_i, 2) && $past(ad_i[1:0], 2) == 2'h0
    && $past(cbe_n_i[3:1], 2) == 3'h5) else $error("bad config claim");
  cmd_legal_a: assert property (lb_valid_o |->
    $past(cbe_n_i, 2) inside {4'h2, 4'h3, 4'h6, 4'h7, 4'hc, 4'he, 4'hf})
    else $error("image claim on wrong command");
  devsel_cause_a: assert property ($fell(devsel_n_o) |-> lb_valid_o || cfg_claim_o)
    else $error("devsel without claim");
  devsel_free_a: assert property (end_s |=> rel_s)
    else $error("devsel release wrong");
endmodule
bind ptid_decoder ptid_checker u_ptid_checker (.*);

// *** tb/ptid_pci_master.sv ***
// Purpose : PCI initiator model, one data phase a cycle
// Assumes : Driven by the bench through run
// Notes   : Released AD lines show the inverse value
`timescale 1ns/100ps
module ptid_pci_master (
  input  wire logic        clk_i,
  output logic             frame_n_o,
  output logic             irdy_n_o,
  output logic             idsel_o,
  output logic [31:0]      ad_o,
  output logic [3:0]       cbe_n_o
);
  initial {frame_n_o, irdy_n_o, idsel_o, ad_o, cbe_n_o} = {3'b110, 32'h0, 4'hf};
  task automatic run(input logic [31:0] a, input logic [3:0] c, input logic s, input int w);
    @(posedge clk_i);
    {frame_n_o, ad_o, cbe_n_o, idsel_o} <= {1'b0, a, c, s};
    @(posedge clk_i);
    {frame_n_o, irdy_n_o, ad_o, cbe_n_o, idsel_o} <= {2'b10, ~a, 4'h0, ~s};
    repeat (w + 1) @(posedge clk_i);
    irdy_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// *** tb/tb_ptid_decoder.sv ***
// Purpose : Self-checking bench for the PCI target image decoder
// Assumes : Partner master makes single data phase cycles
// Notes   : Random image setups from a fixed xorshift seed
`timescale 1ns/100ps
module tb_ptid_decoder;
  logic clk_i, arst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, e;
  logic frame_n_i, irdy_n_i, idsel_i, devsel_n_o, devsel_oe_n_o, cfg_claim_o, cfg_write_o;
  logic lb_valid_o, lb_image_o, lb_write_o, lb_io_o, lb_posted_o, lb_prefetch_o, lb_burst_write_o;
  logic lb_byte_order_o, lb_burst4_o, lb_single_beat_prefetch_o, lb_hold_bus_busy_o;
  logic [7:0]  paddr_i, cfg_reg_o;
  logic [31:0] pwdata_i, prdata_o, ad_i, lb_addr_o, ms, mb, rs, t, a, seed = 32'd81681;
  logic [31:0] ctl [2];
  logic [15:0] ba [2], ta [2], m;
  logic [3:0]  pstrb_i, cbe_n_i, lb_tc_o;
  logic [1:0]  lb_port_width_o;
  logic [5:0]  lb_prefetch_count_o;
  logic [55:0] q [$], x, y;
  int          err_count, compares;
  ptid_decoder u_ptid_decoder (.*);
  ptid_pci_master u_ptid_pci_master (.clk_i(clk_i), .frame_n_o(frame_n_i), .irdy_n_o(irdy_n_i),
    .idsel_o(idsel_i), .ad_o(ad_i), .cbe_n_o(cbe_n_i));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [55:0] ex, input logic [55:0] got);
    compares++;
    if (ex !== got) begin
      err_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, ex, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, ad, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rs = prdata_o;
    e = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
  endtask
  function automatic logic [55:0] exp_of(logic [31:0] ad, logic [3:0] c, logic s);
    logic [31:0] k;
    logic [15:0] mk;
    if (s && ad[1:0] == 2'h0 && c inside {4'ha, 4'hb}) return {2'b11, 45'h0, c[0], ad[7:0]};
    for (int i = 0; i < 2; i++) begin
      k = ctl[i];
      mk = 16'hffff << k[27:24];
      if (k[31] && (k[30] ? c inside {4'h2, 4'h3} : c inside {4'h6, 4'h7, 4'hc, 4'he, 4'hf})
          && ((ad[31:16] ^ ba[i]) & mk) == 16'h0)
        return {2'b10, 1'(i), (ta[i] & mk) | (ad[31:16] & ~mk), ad[15:0], c[0], k[30], k[23:20],
                k[17:16] == 2'h3 ? 2'h0 : k[17:16], c[0] & k[3], !c[0] & k[2],
                (i == 1 && mb[8]) ? mb[5:0] : ms[5:0], c[0] & k[1], ms[8] ^ k[0], mb[11:9]};
    end
    return '0;
  endfunction
  always @(posedge clk_i) begin
    if (lb_valid_o === 1'b1 || cfg_claim_o === 1'b1) begin
      y = cfg_claim_o ? {2'b11, 45'h0, cfg_write_o, cfg_reg_o} : {2'b10, lb_image_o, lb_addr_o,
          lb_write_o, lb_io_o, lb_tc_o, lb_port_width_o, lb_posted_o, lb_prefetch_o, lb_prefetch_count_o,
          lb_burst_write_o, lb_byte_order_o, lb_hold_bus_busy_o, lb_single_beat_prefetch_o, lb_burst4_o};
      chk(q.size() ? q.pop_front() : ~y, y);
    end
  end
  task automatic end_sim;
    $display("counts compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    end_sim;
  end
  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, pstrb_i, arst_n_i} = {43'h0, 4'hf, 1'b0};
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    apb(1'b0, ptid_pkg::STATUS_OFF, 32'h0);
    chk({e, rs}, 33'h1);
    apb(1'b0, 8'h1c, 32'h0);
    chk({e, rs}, {1'b1, 32'h0});
    $display("test reset_map done");
    for (int k = 0; k < 6; k++) begin
      ms = rnd() & 32'h13f;
      mb = rnd() & 32'hf3f;
      apb(1'b1, ptid_pkg::MISC_OFF, ms);
      apb(1'b1, ptid_pkg::MISC_B_OFF, mb);
      for (int i = 0; i < 2; i++) begin
        ctl[i] = rnd() & 32'hcff3000f;
        ctl[i][31] = k != 0 && k != i + 1;
        if (k == 3) ctl[i][27:24] = i ? 4'hf : 4'h0;
        t = rnd();
        ba[i] = {i ? ~ba[0][15] : t[31], t[30:16]} & (16'hffff << ctl[i][27:24]);
        ta[i] = t[15:0];
        apb(1'b1, 8'(i * 8), {ba[i], ta[i]});
        apb(1'b1, 8'(i * 8 + 4), ctl[i]);
      end
      for (int n = 0; n < 16; n++) begin
        a = rnd();
        m = 16'hffff << ctl[a[8]][27:24];
        if (a[9]) a[31:16] = ba[a[8]] | (a[31:16] & ~m);
        if (a[11]) a[1:0] = 2'h0;
        x = exp_of(a, 4'(n), a[10] | a[11]);
        if (x[55]) q.push_back(x);
        u_ptid_pci_master.run(a, 4'(n), a[10] | a[11], a[5:4]);
      end
      $display("test setup %0d done", k);
    end
    apb(1'b0, ptid_pkg::STATUS_OFF, 32'h0);
    chk(rs[1:0], ptid_pkg::DEVSEL_MEDIUM);
    chk(56'(q.size()), 56'h0);
    end_sim;
  end
endmodule
